//--- src/imv_pkg.sv
package imv_pkg;

  // ---------------------------------------------------------------
  // register byte addresses (printed offsets are indices, x4)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CLR_ROW01 = 8'hda;
  localparam logic [7:0] IDX_CLR_BASE  = 8'hdb;
  localparam logic [7:0] IDX_CLR_ROW2  = 8'hdc;
  localparam logic [7:0] IDX_CLR_MISC  = 8'hdd;
  localparam logic [7:0] IDX_MSK_MISC  = 8'hde;
  localparam logic [7:0] IDX_MSK_ROW2  = 8'hdf;
  localparam logic [7:0] IDX_MSK_BASE  = 8'he0;
  localparam logic [7:0] IDX_MSK_ROW01 = 8'he1;
  localparam logic [7:0] IDX_VEC_CLR   = 8'he2;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'he8;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'he9;
  localparam int         ADDR_W        = 10;

  // ---------------------------------------------------------------
  // source numbering: base 0..7, row01 8..15, row2 16..19, misc 20..25
  // ---------------------------------------------------------------
  localparam int          NSRC         = 26;
  localparam int          SRC_ROW01    = 8;
  localparam int          SRC_ROW2     = 16;
  localparam int          SRC_MISC     = 20;
  localparam int          ROW2_BITS    = 4;
  localparam int          MISC_BITS    = 6;
  localparam int          SWINT_BIT    = 7;
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [25:0] RST_SRC      = 26'h0;
  // vector code = base + 4 * source index
  localparam logic [7:0]  VEC_BASE     = 8'h04;
  localparam logic [7:0]  VEC_STEP     = 8'h04;
  localparam logic [7:0]  VEC_NONE     = 8'h00;

  // status / mask bits of the block's own interrupt
  localparam int          EV_PEND      = 0;
  localparam int          EV_SWPOST    = 1;
  localparam logic [1:0]  RST_EV       = 2'h0;

endpackage : imv_pkg

//--- src/imv_regs.sv
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - mask bit 0 masks, 1 unmasks source
// - masked sources still record posted interrupts
// - mask only blocks posted becoming pending
// - misc mask: analog 5/4, rtc, converter, i2c
// - row-two mask holds four low bits
// - base mask bit layout, resets zero
// - row 1 high nibble, row 0 low
// - vector read returns lowest-index pending vector
// - vector write clears all posted, pending
// - vector register eight bits, resets zero
// - soft enable plus write one posts
// - soft disabled, write zero clears posted
// - clear register reads posted flags
module imv_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [25:0] src_irq,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  output logic      [25:0] pending_out,
  output logic             irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [25:0] posted;
    logic [25:0] mask;
    logic        swint_en;
    logic [7:0]  vec;
    logic [25:0] pend;
    logic [1:0]  ev_stat;
    logic [1:0]  ev_mask;
    logic        irq;
    logic        ack;
    logic        waitreq;
    logic [31:0] rdata;
    logic [1:0]  resp;
  } imv_state_t;

  imv_state_t s_r;
  imv_state_t s_nxt;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // a request is taken only while no answer is out, so a request held
  // through its answer cycle is never taken twice
  logic [7:0] idx;
  logic       req;
  logic       wr_go;
  logic       rd_go;
  logic       hit;

  assign idx   = avs_address[9:2];
  assign req   = (avs_read | avs_write) & ~s_r.ack;
  assign wr_go = avs_write & ~s_r.ack & avs_byteenable[0];
  assign rd_go = avs_read & ~s_r.ack;

  // ---------------------------------------------------------------
  // address match
  // ---------------------------------------------------------------
  // unmapped or misaligned words get an error answer, never a stall
  always_comb begin
    unique case (idx)
      imv_pkg::IDX_CLR_ROW01, imv_pkg::IDX_CLR_BASE,
      imv_pkg::IDX_CLR_ROW2,  imv_pkg::IDX_CLR_MISC,
      imv_pkg::IDX_MSK_MISC,  imv_pkg::IDX_MSK_ROW2,
      imv_pkg::IDX_MSK_BASE,  imv_pkg::IDX_MSK_ROW01,
      imv_pkg::IDX_VEC_CLR,   imv_pkg::IDX_IRQ_STAT,
      imv_pkg::IDX_IRQ_MASK: hit = (avs_address[1:0] == 2'h0);
      default: hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0]  wb;
    logic [25:0] sel;
    logic [25:0] wv;
    logic [25:0] set_hw;
    logic [25:0] pend_n;
    logic [7:0]  vec_n;
    logic        vclr;
    logic        swpost;
    wb     = avs_writedata[7:0];
    sel    = '0;
    wv     = '0;
    set_hw = src_irq;
    vclr   = 1'b0;
    vec_n  = imv_pkg::VEC_NONE;
    pend_n = imv_pkg::RST_SRC;
    swpost = 1'b0;
    s_nxt  = s_r;

    // ---------------------------------------------------------------
    // posted flags
    // ---------------------------------------------------------------
    // write to a clear register selects one group of posted flags
    // reserved upper bits of such a write are dropped here
    if (wr_go) begin
      unique case (idx)
        imv_pkg::IDX_CLR_BASE: begin
          sel[7:0] = 8'hff;
          wv[7:0]  = wb;
        end
        imv_pkg::IDX_CLR_ROW01: begin
          sel[15:8] = 8'hff;
          wv[15:8]  = wb;
        end
        imv_pkg::IDX_CLR_ROW2: begin
          sel[19:16] = 4'hf;
          wv[19:16]  = wb[3:0];
        end
        imv_pkg::IDX_CLR_MISC: begin
          sel[25:20] = 6'h3f;
          wv[25:20]  = wb[5:0];
        end
        default: begin
          sel = '0;
        end
      endcase
    end

    // ---------------------------------------------------------------
    // software post and clear
    // ---------------------------------------------------------------
    // clear and post act only on the selected group
    // soft post on ones
    swpost = s_r.swint_en & |(sel & wv);
    for (int i = 0; i < imv_pkg::NSRC; i++) begin
      if (sel[i] && s_r.swint_en && wv[i]) begin
        set_hw[i] = 1'b1;
      end
      // posting ignores mask
      // set wins over a same-cycle clear
      if (sel[i] && !s_r.swint_en && !wv[i]) begin
        s_nxt.posted[i] = set_hw[i];
      end else begin
        s_nxt.posted[i] = s_r.posted[i] | set_hw[i];
      end
    end

    // ---------------------------------------------------------------
    // mask registers and flush
    // ---------------------------------------------------------------
    // mask bit unmasks at one
    if (wr_go) begin
      unique case (idx)
        imv_pkg::IDX_MSK_BASE:  s_nxt.mask[7:0]   = wb;
        imv_pkg::IDX_MSK_ROW01: s_nxt.mask[15:8]  = wb;
        imv_pkg::IDX_MSK_ROW2:  s_nxt.mask[19:16] = wb[3:0];
        imv_pkg::IDX_MSK_MISC: begin
          s_nxt.mask[25:20] = wb[5:0];
          s_nxt.swint_en    = wb[imv_pkg::SWINT_BIT];
        end
        imv_pkg::IDX_VEC_CLR: vclr = 1'b1;
        imv_pkg::IDX_IRQ_MASK: s_nxt.ev_mask = wb[1:0];
        default: vclr = 1'b0;
      endcase
    end
    // flush posted, pending follows
    // a flush also discards a source event landing in the same cycle
    if (vclr) begin
      s_nxt.posted = imv_pkg::RST_SRC;
    end

    // ---------------------------------------------------------------
    // pending and vector
    // ---------------------------------------------------------------
    // pending is posted and mask
    pend_n = s_nxt.posted & s_nxt.mask;
    // lowest index has highest priority
    // vector is registered with pending, so a read sees a settled pair
    for (int i = imv_pkg::NSRC - 1; i >= 0; i--) begin
      if (pend_n[i]) begin
        vec_n = 8'(imv_pkg::VEC_BASE + 8'(i) * imv_pkg::VEC_STEP);
      end
    end
    s_nxt.pend = pend_n;
    s_nxt.vec  = vec_n;

    // ---------------------------------------------------------------
    // event status
    // ---------------------------------------------------------------
    // sticky events, write one to clear, set wins
    // pending event fires on the step from none to some
    if (wr_go && idx == imv_pkg::IDX_IRQ_STAT) begin
      s_nxt.ev_stat = s_r.ev_stat & ~wb[1:0];
    end
    if (|pend_n && !(|s_r.pend)) begin
      s_nxt.ev_stat[imv_pkg::EV_PEND] = 1'b1;
    end
    if (swpost) begin
      s_nxt.ev_stat[imv_pkg::EV_SWPOST] = 1'b1;
    end
    // level output, high while an unmasked event bit is set
    s_nxt.irq = |(s_nxt.ev_stat & s_nxt.ev_mask);

    // ---------------------------------------------------------------
    // bus answer
    // ---------------------------------------------------------------
    // one wait cycle, then ack; waitrequest is its own flop so the
    // port comes straight from a register
    s_nxt.ack   = req;
    s_nxt.waitreq = ~req;
    s_nxt.resp  = 2'h0;
    s_nxt.rdata = '0;
    // an unmapped request still gets its one-cycle answer
    if (req && !hit) begin
      s_nxt.resp = 2'h2;
    end
    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    // reserved bits read as zero
    if (rd_go) begin
      unique case (idx)
        imv_pkg::IDX_CLR_BASE:  s_nxt.rdata[7:0] = s_r.posted[7:0];
        imv_pkg::IDX_CLR_ROW01: s_nxt.rdata[7:0] = s_r.posted[15:8];
        imv_pkg::IDX_CLR_ROW2:  s_nxt.rdata[3:0] = s_r.posted[19:16];
        imv_pkg::IDX_CLR_MISC:  s_nxt.rdata[5:0] = s_r.posted[25:20];
        imv_pkg::IDX_MSK_BASE:  s_nxt.rdata[7:0] = s_r.mask[7:0];
        imv_pkg::IDX_MSK_ROW01: s_nxt.rdata[7:0] = s_r.mask[15:8];
        imv_pkg::IDX_MSK_ROW2:  s_nxt.rdata[3:0] = s_r.mask[19:16];
        imv_pkg::IDX_MSK_MISC: begin
          s_nxt.rdata[5:0] = s_r.mask[25:20];
          s_nxt.rdata[7]   = s_r.swint_en;
        end
        imv_pkg::IDX_VEC_CLR:  s_nxt.rdata[7:0] = s_r.vec;
        imv_pkg::IDX_IRQ_STAT: s_nxt.rdata[1:0] = s_r.ev_stat;
        imv_pkg::IDX_IRQ_MASK: s_nxt.rdata[1:0] = s_r.ev_mask;
        default: s_nxt.rdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r.posted   <= imv_pkg::RST_SRC;
      s_r.mask     <= imv_pkg::RST_SRC;
      s_r.swint_en <= 1'b0;
      s_r.vec      <= imv_pkg::RST_BYTE;
      s_r.pend     <= imv_pkg::RST_SRC;
      s_r.ev_stat  <= imv_pkg::RST_EV;
      s_r.ev_mask  <= imv_pkg::RST_EV;
      s_r.irq      <= 1'b0;
      s_r.ack      <= 1'b0;
      s_r.waitreq  <= 1'b1;
      s_r.rdata    <= 32'h0;
      s_r.resp     <= 2'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // every port is a register bit, no logic after the flops
  assign avs_waitrequest = s_r.waitreq;
  assign avs_readdata    = s_r.rdata;
  assign avs_response    = s_r.resp;
  assign pending_out     = s_r.pend;
  assign irq             = s_r.irq;

endmodule // imv_regs

//--- verif/imv_src_model.sv
`timescale 1ns/1ps
module imv_src_model (
  input  wire logic        sys_clk,
  output logic      [25:0] src_irq
);
  initial src_irq = 26'h0;
  // one-cycle request pulse, the shortest a source may give
  task automatic pulse(input int i);
    @(posedge sys_clk);
    src_irq[i] <= 1'b1;
    @(posedge sys_clk);
    src_irq[i] <= 1'b0;
  endtask
endmodule // imv_src_model

//--- verif/imv_regs_assertions.sv
`timescale 1ns/1ps
module imv_regs_assertions (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [25:0] src_irq,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  input wire logic [25:0] pending_out,
  input wire logic        irq
);
  wire [7:0] ix = avs_address[9:2];
  wire       ack = !avs_waitrequest;
  wire       ok = avs_address[1:0] == 2'h0
                  && (ix >= 8'hda && ix <= 8'he2 || ix[7:1] == 7'h74);
  // lowest source index wins
  function automatic logic [7:0] vec(input logic [25:0] p);
    vec = imv_pkg::VEC_NONE;
    for (int i = 25; i >= 0; i--)
      if (p[i]) vec = 8'(imv_pkg::VEC_BASE + imv_pkg::VEC_STEP * 8'(i));
  endfunction
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_wait_one: assert property ((avs_read || avs_write) && !ack |=> ack)
    else $error("answer not after one wait state");
  a_wait_pulse: assert property (ack |=> !ack)
    else $error("waitrequest low for more than one cycle");
  a_unmapped_err: assert property (ack && avs_read && !ok
    |-> avs_response == 2'h2 && avs_readdata == 32'h0)
    else $error("unmapped read not refused");
  a_row2_resv: assert property (
    ack && avs_read && ok && (ix == 8'hdc || ix == 8'hdf)
    |-> avs_readdata[31:4] == 28'h0) else $error("row two reserved set");
  a_vec_read: assert property (
    ack && avs_read && ok && ix == 8'he2 && $stable(pending_out)
    && pending_out == $past(pending_out, 2)
    |-> avs_readdata == {24'h0, vec(pending_out)})
    else $error("wrong vector read");
  a_vclr_flush: assert property (
    ack && avs_write && avs_byteenable[0] && ok && ix == 8'he2
    && src_irq == 26'h0
    |=> pending_out == 26'h0) else $error("vector write left pending");
  a_pend_cause: assert property (
    (pending_out & ~$past(pending_out)) != 26'h0
    |-> $past(avs_write) || $past(avs_write, 2)
    || $past(src_irq) != 26'h0 || $past(src_irq, 2) != 26'h0)
    else $error("pending rose without cause");
  a_irq_fall: assert property ($fell(irq)
    |-> $past(avs_write) || $past(avs_write, 2))
    else $error("irq dropped without a write");
endmodule // imv_regs_assertions
bind imv_regs imv_regs_assertions i_imv_regs_assertions (
  .sys_clk(sys_clk), .rst_n(rst_n), .src_irq(src_irq),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .pending_out(pending_out), .irq(irq));

//--- verif/imv_regs_tb.sv
`timescale 1ns/1ps
module imv_regs_tb;
  logic        sys_clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [9:0]  adr = 10'h0;
  logic [31:0] wd = 32'h0, rdat;
  logic [25:0] src_irq, pend;
  logic [1:0]  rsp;
  logic        wt, irq;
  logic [3:0]  be = 4'hf;
  int          mismatches = 0, num_checks = 0;
  always #25 sys_clk = ~sys_clk;
  imv_src_model i_imv_src_model (.sys_clk(sys_clk), .src_irq(src_irq));
  imv_regs i_imv_regs (
    .sys_clk(sys_clk), .rst_n(rst_n), .src_irq(src_irq),
    .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wt), .avs_response(rsp), .pending_out(pend),
    .irq(irq));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // write d, or read and compare against d; values sampled at the edge
  task automatic acc(input logic w, input logic [7:0] i, d);
    int n;
    @(posedge sys_clk);
    adr <= {i, 2'h0};
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    for (n = 0; n < 20 && wt !== 1'b0; n++)
      @(posedge sys_clk);
    if (!w)
      chk(rdat, {24'h0, d});
    wr <= 1'b0;
    rd <= 1'b0;
    if (n == 20) begin
      mismatches++;
      stop_test();
    end
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    acc(0, 8'he0, 8'h00);
    acc(0, 8'he2, 8'h00);
    acc(1, 8'hdf, 8'h0f);
    acc(0, 8'hdf, 8'h0f);
    acc(1, 8'he1, 8'h5a);
    acc(0, 8'he1, 8'h5a);
    acc(1, 8'he1, 8'h00);
    i_imv_src_model.pulse(5);
    acc(0, 8'hdb, 8'h20);
    acc(0, 8'he2, 8'h00);
    acc(1, 8'he0, 8'h20);
    acc(0, 8'he2, 8'h18);
    i_imv_src_model.pulse(1);
    acc(0, 8'he2, 8'h18);
    acc(1, 8'he0, 8'h22);
    acc(0, 8'he2, 8'h08);
    chk({6'h0, pend}, 32'h22);
    acc(1, 8'he9, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    acc(1, 8'he9, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    acc(0, 8'he8, 8'h01);
    acc(1, 8'he8, 8'h01);
    acc(0, 8'he8, 8'h00);
    acc(1, 8'he2, 8'h55);
    acc(0, 8'hdb, 8'h00);
    acc(0, 8'he2, 8'h00);
    chk({6'h0, pend}, 32'h0);
    be <= 4'he;
    acc(1, 8'he1, 8'hff);
    be <= 4'hf;
    acc(0, 8'he1, 8'h00);
    i_imv_src_model.pulse(19);
    acc(0, 8'hdc, 8'h08);
    i_imv_src_model.pulse(23);
    acc(0, 8'hdd, 8'h08);
    i_imv_src_model.pulse(15);
    acc(0, 8'hda, 8'h80);
    acc(1, 8'hde, 8'h80);
    acc(1, 8'hdc, 8'h04);
    acc(0, 8'hdc, 8'h0c);
    acc(1, 8'hde, 8'h00);
    acc(1, 8'hdc, 8'h08);
    acc(0, 8'hdc, 8'h08);
    acc(0, 8'h00, 8'h00);
    chk({30'h0, rsp}, 32'h2);
    stop_test();
  end
endmodule // imv_regs_tb
